/* File: core/rst_vec_pkg.sv */
// Constants and types for the reset source and vector control block.
package rst_vec_pkg;
  localparam int VEC_W = 10;
  localparam logic [VEC_W-1:0] VEC_RESET = 10'h000;
  localparam logic [VEC_W-1:0] VEC_EXT = 10'h001;
  localparam logic [VEC_W-1:0] VEC_TMR = 10'h002;

  localparam int APB_ADDR_W = 8;
  localparam logic [APB_ADDR_W-1:0] ADDR_CAUSE = 8'h00;
  localparam logic [APB_ADDR_W-1:0] ADDR_IRQ_EN = 8'h04;
  localparam logic [APB_ADDR_W-1:0] ADDR_EVT_STAT = 8'h08;
  localparam logic [APB_ADDR_W-1:0] ADDR_EVT_MASK = 8'h0c;

  localparam int CAUSE_W = 2;
  localparam int CAUSE_REG_W = 8;
  localparam int CAUSE_POWER_BIT = 0;
  localparam int CAUSE_PIN_BIT = 1;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 2'h1;

  localparam int EN_EXT_BIT = 0;
  localparam int EN_TMR_BIT = 1;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;

  localparam int EVT_W = 4;
  localparam int EVT_POWER_BIT = 0;
  localparam int EVT_PIN_BIT = 1;
  localparam int EVT_WDOG_BIT = 2;
  localparam int EVT_DONE_BIT = 3;
  localparam logic [EVT_W-1:0] EVT_STAT_RESET = 4'h1;
  localparam logic [EVT_W-1:0] EVT_MASK_RESET = 4'h0;

  localparam int STARTUP_SHORT_CYCLES = 1024;
  localparam int STARTUP_LONG_CYCLES = 16384;
  localparam int STARTUP_RC_CYCLES = 1;

  // One request line per interrupt source
  typedef struct packed {
    logic tmr;
    logic ext;
  } irq_req_t;

  // Vector chosen for the core
  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] addr;
  } vec_grant_t;

  // True when the address selects the given register
  function automatic logic addr_hit(input logic [APB_ADDR_W-1:0] a,
                                    input logic [APB_ADDR_W-1:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction
endpackage

/* File: core/startup_delay_timer.sv */
// Start-up delay counter advanced by watchdog oscillator ticks.
`timescale 1ns/1ps
`default_nettype none
module startup_delay_timer #(
  parameter int LONG_CYCLES = rst_vec_pkg::STARTUP_LONG_CYCLES,
  parameter int SHORT_CYCLES = rst_vec_pkg::STARTUP_SHORT_CYCLES,
  parameter bit RC_VARIANT = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic osc_tick_i,
  input wire logic short_fuse_i,
  output logic busy_o
);
  import rst_vec_pkg::*;

  localparam int CNT_W = $clog2(LONG_CYCLES + 1);

  if (LONG_CYCLES < 1 || SHORT_CYCLES < 1 || SHORT_CYCLES > LONG_CYCLES) begin : g_chk
    $error("startup_delay_timer: cycle counts out of range");
  end

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic [CNT_W-1:0] load_len;

  // Length is chosen at load time so a fuse change mid-count has no effect
  always_comb begin
    if (RC_VARIANT) begin
      load_len = CNT_W'(STARTUP_RC_CYCLES);
    end else if (short_fuse_i) begin
      load_len = CNT_W'(SHORT_CYCLES);
    end else begin
      load_len = CNT_W'(LONG_CYCLES);
    end
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    if (start_i) begin
      cnt_next = load_len;
      busy_next = 1'b1;
    end else if (busy_reg && osc_tick_i) begin
      // Only watchdog oscillator ticks advance the count, not the CPU clock
      cnt_next = cnt_reg - CNT_W'(1);
      busy_next = (cnt_reg > CNT_W'(1));
    end
  end

  // Busy from reset: power-on is held until the first load has run out
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_o = busy_reg;
endmodule
`default_nettype wire

/* File: core/irq_priority_arbiter.sv */
// Fixed-priority choice between reset and the two interrupt sources.
`timescale 1ns/1ps
`default_nettype none
module irq_priority_arbiter (
  input wire logic reset_pending_i,
  input wire logic hold_i,
  input wire logic global_en_i,
  input wire rst_vec_pkg::irq_req_t req_i,
  input wire rst_vec_pkg::irq_req_t en_i,
  output rst_vec_pkg::vec_grant_t grant_o
);
  import rst_vec_pkg::*;

  irq_req_t live;

  // A source counts only with its own enable and the global enable
  always_comb begin
    live.ext = req_i.ext && en_i.ext && global_en_i;
    live.tmr = req_i.tmr && en_i.tmr && global_en_i;
    grant_o.valid = 1'b0;
    grant_o.addr = VEC_RESET;
    // Lower address first: reset, then external, then timer
    if (reset_pending_i) begin
      grant_o.valid = 1'b1;
      grant_o.addr = VEC_RESET;
    end else if (hold_i) begin
      grant_o.valid = 1'b0;
    end else if (live.ext) begin
      grant_o.valid = 1'b1;
      grant_o.addr = VEC_EXT;
    end else if (live.tmr) begin
      grant_o.valid = 1'b1;
      grant_o.addr = VEC_TMR;
    end
  end
endmodule
`default_nettype wire

/* File: core/reset_source_and_vector_control.sv */
// Reset merging, start-up delay, reset cause flags and vector selection.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module reset_source_and_vector_control #(
  parameter int LONG_CYCLES = rst_vec_pkg::STARTUP_LONG_CYCLES,
  parameter int SHORT_CYCLES = rst_vec_pkg::STARTUP_SHORT_CYCLES,
  parameter bit RC_VARIANT = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rst_vec_pkg::APB_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_reset_n_i,
  input wire logic watchdog_expire_i,
  input wire logic wdog_osc_tick_i,
  input wire logic short_startup_fuse_i,
  input wire logic global_irq_en_i,
  input wire rst_vec_pkg::irq_req_t irq_req_i,
  input wire logic vec_ack_i,
  output logic core_reset_o,
  output logic vec_valid_o,
  output logic [rst_vec_pkg::VEC_W-1:0] vec_addr_o,
  output logic irq_o
);
  import rst_vec_pkg::*;

  logic delay_busy;
  vec_grant_t grant;

  logic por_start_reg, por_start_next;
  logic pin_low_reg, pin_low_next;
  logic expire_prev_reg, expire_prev_next;
  logic wdog_pulse_reg, wdog_pulse_next;
  logic busy_prev_reg, busy_prev_next;
  logic core_reset_reg, core_reset_next;
  logic reset_pending_reg, reset_pending_next;
  logic vec_valid_reg, vec_valid_next;
  logic [VEC_W-1:0] vec_addr_reg, vec_addr_next;
  logic [CAUSE_W-1:0] cause_reg, cause_next;
  logic [1:0] irq_en_reg, irq_en_next;
  logic [EVT_W-1:0] evt_stat_reg, evt_stat_next;
  logic [EVT_W-1:0] evt_mask_reg, evt_mask_next;
  logic [EVT_W-1:0] rd_clr_reg, rd_clr_next;
  logic irq_reg, irq_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pin_start, delay_start, done_evt;
  logic acc_fire, wr_fire, rd_fire, mapped;
  logic [EVT_W-1:0] evt_set;
  irq_req_t en_s;

  // Start-up delay counted in watchdog oscillator ticks
  startup_delay_timer #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES),
    .RC_VARIANT(RC_VARIANT)
  ) u_delay (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .start_i(delay_start),
    .osc_tick_i(wdog_osc_tick_i),
    .short_fuse_i(short_startup_fuse_i),
    .busy_o(delay_busy)
  );

  assign en_s.ext = irq_en_reg[EN_EXT_BIT];
  assign en_s.tmr = irq_en_reg[EN_TMR_BIT];

  // Vector choice; reset vector outranks every interrupt
  irq_priority_arbiter u_arb (
    .reset_pending_i(reset_pending_reg),
    .hold_i(core_reset_reg),
    .global_en_i(global_irq_en_i),
    .req_i(irq_req_i),
    .en_i(en_s),
    .grant_o(grant)
  );

  // Reset sources: pin release and the end of the watchdog pulse start the delay
  always_comb begin
    por_start_next = 1'b0;
    pin_low_next = !ext_reset_n_i;
    expire_prev_next = watchdog_expire_i;
    // Edge detect keeps the pulse one cycle even if expiry is held high
    wdog_pulse_next = watchdog_expire_i && !expire_prev_reg;
    busy_prev_next = delay_busy;
    pin_start = pin_low_reg && ext_reset_n_i;
    // Falling edge of the pulse is the cycle after it was high
    delay_start = por_start_reg || pin_start || wdog_pulse_reg;
    done_evt = busy_prev_reg && !delay_busy;
    core_reset_next = !ext_reset_n_i || watchdog_expire_i || wdog_pulse_reg
                      || delay_start || delay_busy;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_start_reg <= 1'b1;
      pin_low_reg <= 1'b0;
      expire_prev_reg <= 1'b0;
      wdog_pulse_reg <= 1'b0;
      busy_prev_reg <= 1'b1;
      core_reset_reg <= 1'b1;
    end else begin
      por_start_reg <= por_start_next;
      pin_low_reg <= pin_low_next;
      expire_prev_reg <= expire_prev_next;
      wdog_pulse_reg <= wdog_pulse_next;
      busy_prev_reg <= busy_prev_next;
      core_reset_reg <= core_reset_next;
    end
  end

  // Vector request to the core, held until acknowledged
  always_comb begin
    reset_pending_next = reset_pending_reg;
    vec_valid_next = vec_valid_reg;
    vec_addr_next = vec_addr_reg;
    if (core_reset_next) begin
      reset_pending_next = 1'b1;
      vec_valid_next = 1'b0;
    end else if (vec_valid_reg && vec_ack_i) begin
      vec_valid_next = 1'b0;
      if (vec_addr_reg == VEC_RESET) begin
        reset_pending_next = 1'b0;
      end
    end else if (!vec_valid_reg && grant.valid) begin
      vec_valid_next = 1'b1;
      vec_addr_next = grant.addr;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_pending_reg <= 1'b1;
      vec_valid_reg <= 1'b0;
      vec_addr_reg <= VEC_RESET;
    end else begin
      reset_pending_reg <= reset_pending_next;
      vec_valid_reg <= vec_valid_next;
      vec_addr_reg <= vec_addr_next;
    end
  end

  // APB slave: one wait state, answer computed in the first access cycle
  always_comb begin
    acc_fire = psel_i && penable_i && pready_reg;
    wr_fire = acc_fire && pwrite_i;
    rd_fire = acc_fire && !pwrite_i;
    mapped = addr_hit(paddr_i, ADDR_CAUSE) || addr_hit(paddr_i, ADDR_IRQ_EN)
             || addr_hit(paddr_i, ADDR_EVT_STAT) || addr_hit(paddr_i, ADDR_EVT_MASK);
    pready_next = psel_i && penable_i && !pready_reg;
    pslverr_next = pready_next && !mapped;
    prdata_next = '0;
    rd_clr_next = rd_clr_reg;
    if (pready_next && !pwrite_i) begin
      rd_clr_next = '0;
      if (addr_hit(paddr_i, ADDR_CAUSE)) begin
        // Upper bits of the cause register stay zero
        prdata_next[CAUSE_W-1:0] = cause_reg;
      end else if (addr_hit(paddr_i, ADDR_IRQ_EN)) begin
        prdata_next[1:0] = irq_en_reg;
      end else if (addr_hit(paddr_i, ADDR_EVT_STAT)) begin
        prdata_next[EVT_W-1:0] = evt_stat_reg;
        rd_clr_next = evt_stat_reg;
      end else if (addr_hit(paddr_i, ADDR_EVT_MASK)) begin
        prdata_next[EVT_W-1:0] = evt_mask_reg;
      end
    end
  end

  // Registers; a hardware set always wins over a software clear
  always_comb begin
    cause_next = cause_reg;
    irq_en_next = irq_en_reg;
    evt_mask_next = evt_mask_reg;
    if (wr_fire && addr_hit(paddr_i, ADDR_CAUSE)) begin
      // Writing one leaves a flag alone, zero clears it
      cause_next = cause_reg & pwdata_i[CAUSE_W-1:0];
    end
    if (!ext_reset_n_i) begin
      cause_next[CAUSE_PIN_BIT] = 1'b1;
    end
    // Watchdog resets touch neither flag; power-on sets bit 0 via reset value
    if (wr_fire && addr_hit(paddr_i, ADDR_IRQ_EN)) begin
      irq_en_next = pwdata_i[1:0];
    end
    if (wr_fire && addr_hit(paddr_i, ADDR_EVT_MASK)) begin
      evt_mask_next = pwdata_i[EVT_W-1:0];
    end
    evt_set = '0;
    evt_set[EVT_PIN_BIT] = pin_start;
    evt_set[EVT_WDOG_BIT] = wdog_pulse_reg;
    evt_set[EVT_DONE_BIT] = done_evt;
    // Only bits that were actually returned are cleared by the read
    evt_stat_next = evt_stat_reg;
    if (rd_fire && addr_hit(paddr_i, ADDR_EVT_STAT)) begin
      evt_stat_next = evt_stat_reg & ~rd_clr_reg;
    end
    evt_stat_next = evt_stat_next | evt_set;
    irq_next = |(evt_stat_next & evt_mask_next);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cause_reg <= CAUSE_RESET;
      irq_en_reg <= IRQ_EN_RESET;
      evt_stat_reg <= EVT_STAT_RESET;
      evt_mask_reg <= EVT_MASK_RESET;
      rd_clr_reg <= '0;
      irq_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      cause_reg <= cause_next;
      irq_en_reg <= irq_en_next;
      evt_stat_reg <= evt_stat_next;
      evt_mask_reg <= evt_mask_next;
      rd_clr_reg <= rd_clr_next;
      irq_reg <= irq_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign core_reset_o = core_reset_reg;
  assign vec_valid_o = vec_valid_reg;
  assign vec_addr_o = vec_addr_reg;
  assign irq_o = irq_reg;

  // Checks on the merged reset and vector behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  a_wdog_pulse_one: assert property (wdog_pulse_reg |=> !wdog_pulse_reg)
    else $error("watchdog reset pulse longer than one cycle");
  // The load lands on the edge that ends the pulse, so busy is seen one edge later
  a_pulse_starts_delay: assert property ($fell(wdog_pulse_reg) |=> delay_busy)
    else $error("delay timer not running after watchdog pulse");
  // Every reset source keeps the core held while it is active
  a_wdog_holds_core: assert property (wdog_pulse_reg |-> core_reset_o)
    else $error("core not held during watchdog pulse");
  a_pin_holds_core: assert property (!ext_reset_n_i |=> core_reset_o)
    else $error("core not held while reset pin is low");
  a_busy_holds_core: assert property (delay_busy |-> ##1 core_reset_o)
    else $error("core released while start-up delay counts");
  a_no_vec_reset: assert property (core_reset_o |-> !vec_valid_o)
    else $error("vector offered while core is held in reset");
  // Release and the reset vector appear on the same edge
  a_reset_vec_first: assert property ($fell(core_reset_o) |-> vec_valid_o
    && vec_addr_o == VEC_RESET)
    else $error("reset vector not offered after release");
  a_vec_legal: assert property (vec_valid_o |-> vec_addr_o == VEC_RESET
    || vec_addr_o == VEC_EXT || vec_addr_o == VEC_TMR)
    else $error("vector outside the three fixed locations");
  // Interrupt vectors need the source, its own enable and the global enable
  a_irq_gated: assert property ($rose(vec_valid_o) && vec_addr_o != VEC_RESET
    |-> $past(global_irq_en_i))
    else $error("interrupt taken with global enable low");
  a_ext_gated: assert property ($rose(vec_valid_o) && vec_addr_o == VEC_EXT
    |-> $past(irq_req_i.ext && irq_en_reg[EN_EXT_BIT]))
    else $error("external vector without an enabled request");
  a_tmr_gated: assert property ($rose(vec_valid_o) && vec_addr_o == VEC_TMR
    |-> $past(irq_req_i.tmr && irq_en_reg[EN_TMR_BIT]))
    else $error("timer vector without an enabled request");
  a_ext_wins: assert property ($rose(vec_valid_o) && vec_addr_o != VEC_RESET
    && $past(irq_req_i.ext && irq_en_reg[EN_EXT_BIT]) |-> vec_addr_o == VEC_EXT)
    else $error("timer vector chosen over external request");
  a_reserved_zero: assert property (pready_o && !pslverr_o && !pwrite_i
    && addr_hit(paddr_i, ADDR_CAUSE) |-> prdata_o[31:CAUSE_W] == '0)
    else $error("reserved cause bits read non-zero");
  // Cause flags: set only by their own reset source, cleared only by software
  a_pin_sets_flag: assert property (!ext_reset_n_i |=> cause_reg[CAUSE_PIN_BIT])
    else $error("pin reset did not set its flag");
  a_wdog_keeps_cause: assert property (wdog_pulse_reg && ext_reset_n_i
    && !(wr_fire && addr_hit(paddr_i, ADDR_CAUSE)) |=> $stable(cause_reg))
    else $error("watchdog reset changed the cause flags");
  a_power_flag_kept: assert property (!cause_reg[CAUSE_POWER_BIT]
    |=> !cause_reg[CAUSE_POWER_BIT])
    else $error("power flag set without a power-on reset");
  a_zero_clears: assert property (wr_fire && addr_hit(paddr_i, ADDR_CAUSE)
    && !pwdata_i[CAUSE_POWER_BIT] |=> !cause_reg[CAUSE_POWER_BIT])
    else $error("writing zero did not clear power flag");
  a_zero_clears_pin: assert property (wr_fire && addr_hit(paddr_i, ADDR_CAUSE)
    && !pwdata_i[CAUSE_PIN_BIT] && ext_reset_n_i |=> !cause_reg[CAUSE_PIN_BIT])
    else $error("writing zero did not clear pin flag");

  c_wdog_reset: cover property (wdog_pulse_reg ##1 delay_busy);
  c_ext_vec: cover property ($rose(vec_valid_o) && vec_addr_o == VEC_EXT);
  c_tmr_vec: cover property ($rose(vec_valid_o) && vec_addr_o == VEC_TMR);
  c_pin_release: cover property (pin_start ##[1:40] !core_reset_o);
endmodule
`default_nettype wire

/* File: testbench/core_partner.sv */
// Partner model: vector-taking core, watchdog oscillator and interrupt flag sources.
`timescale 1ns/1ps
`default_nettype none
module core_partner (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic vec_valid_i,
  input wire logic [rst_vec_pkg::VEC_W-1:0] vec_addr_i,
  input wire logic set_ext_i,
  input wire logic set_tmr_i,
  output logic vec_ack_o,
  output logic osc_tick_o,
  output rst_vec_pkg::irq_req_t irq_req_o,
  output logic taken_o,
  output logic [rst_vec_pkg::VEC_W-1:0] taken_addr_o
);
  import rst_vec_pkg::*;
  logic [1:0] osc_div = 2'h0;
  logic tick_reg = 1'b0;
  logic [1:0] wait_cnt;

  // Own oscillator, one tick every third CPU cycle, running even in reset
  always @(posedge clk_i) begin
    osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
    tick_reg <= (osc_div == 2'h2);
  end
  assign osc_tick_o = tick_reg;

  // Core takes a vector after a random wait; flags clear when their vector runs
  // Entry leaves the global enable alone, software owns it
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vec_ack_o <= 1'b0;
      taken_o <= 1'b0;
      irq_req_o <= '0;
      wait_cnt <= 2'h0;
      taken_addr_o <= '0;
    end else begin
      taken_o <= vec_ack_o && vec_valid_i;
      irq_req_o.ext <= (irq_req_o.ext | set_ext_i) &
        !(vec_ack_o && vec_valid_i && vec_addr_i == VEC_EXT);
      irq_req_o.tmr <= (irq_req_o.tmr | set_tmr_i) &
        !(vec_ack_o && vec_valid_i && vec_addr_i == VEC_TMR);
      if (vec_ack_o && vec_valid_i) begin
        taken_addr_o <= vec_addr_i;
        vec_ack_o <= 1'b0;
        wait_cnt <= 2'($urandom % 4);
      end else if (vec_valid_i && !vec_ack_o) begin
        if (wait_cnt == 2'h0) begin
          vec_ack_o <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/reset_source_and_vector_control_bench.sv */
// Self-checking bench for reset merging, cause flags and vector choice.
`timescale 1ns/1ps
`default_nettype none
module reset_source_and_vector_control_bench;
  import rst_vec_pkg::*;
  localparam int LONG_N = 16;
  localparam int SHORT_N = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ext_n = 1'b1;
  logic wdog = 1'b0;
  logic fuse = 1'b1;
  logic gie = 1'b0;
  logic set_ext = 1'b0;
  logic set_tmr = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic vec_ack;
  wire logic osc_tick;
  wire logic core_reset;
  wire logic vec_valid;
  wire logic [9:0] vec_addr;
  wire logic irq;
  wire logic taken;
  wire logic [9:0] taken_addr;
  wire logic rc_core_reset;
  int rc_ticks = 0;
  irq_req_t irq_req;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int ticks = 0;
  int bad_vec = 0;
  int taken_n = 0;
  int n0;
  int cause_m;
  logic [31:0] rd;
  logic err;
  logic [1:0] en;
  logic g;

  reset_source_and_vector_control #(.LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N),
    .RC_VARIANT(1'b0)) dut (.clk_sys_i(clk), .arst_n_i(arst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ext_reset_n_i(ext_n),
    .watchdog_expire_i(wdog), .wdog_osc_tick_i(osc_tick), .short_startup_fuse_i(fuse),
    .global_irq_en_i(gie), .irq_req_i(irq_req), .vec_ack_i(vec_ack),
    .core_reset_o(core_reset), .vec_valid_o(vec_valid), .vec_addr_o(vec_addr),
    .irq_o(irq));

  core_partner partner (.clk_i(clk), .arst_n_i(arst_n), .vec_valid_i(vec_valid),
    .vec_addr_i(vec_addr), .set_ext_i(set_ext), .set_tmr_i(set_tmr), .vec_ack_o(vec_ack),
    .osc_tick_o(osc_tick), .irq_req_o(irq_req), .taken_o(taken), .taken_addr_o(taken_addr));

  // Internal-RC variant, watched only for the length of its power-on hold
  reset_source_and_vector_control #(.RC_VARIANT(1'b1)) dut_rc (.clk_sys_i(clk),
    .arst_n_i(arst_n), .psel_i(1'b0), .penable_i(1'b0), .pwrite_i(1'b0), .paddr_i(8'h00),
    .pwdata_i(32'h0), .prdata_o(), .pready_o(), .pslverr_o(), .ext_reset_n_i(1'b1),
    .watchdog_expire_i(1'b0), .wdog_osc_tick_i(osc_tick), .short_startup_fuse_i(fuse),
    .global_irq_en_i(1'b0), .irq_req_i('0), .vec_ack_i(1'b1),
    .core_reset_o(rc_core_reset), .vec_valid_o(), .vec_addr_o(), .irq_o());

  always #2.5 clk = ~clk;

  // Tick and handshake tallies, vector-under-reset watch, hang limit
  always @(posedge clk) begin
    cycles++;
    if (osc_tick === 1'b1 && core_reset === 1'b1) ticks++;
    if (osc_tick === 1'b1 && rc_core_reset === 1'b1) rc_ticks++;
    if (core_reset === 1'b1 && vec_valid === 1'b1) bad_vec++;
    if (taken === 1'b1) taken_n++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_vec(input logic [9:0] e);
    for (int k = 0; k < 400 && taken !== 1'b1; k++) @(negedge clk);
    chk("vector", {21'h0, 1'b1, e}, {21'h0, taken, taken_addr});
    @(negedge clk);
  endtask

  // Start-up length seen in oscillator ticks, one tick of slack for the load edge
  task automatic chk_delay(input int n, input int t);
    chk("startup ticks", 32'h1, {31'h0, t >= n && t <= n + 1});
  endtask

  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h37ed));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    ticks = 0;
    rc_ticks = 0;
    wait_vec(VEC_RESET);
    chk_delay(SHORT_N, ticks);
    chk_delay(STARTUP_RC_CYCLES, rc_ticks);
    cause_m = 1;
    apb(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause", cause_m, rd);
    apb(1'b0, ADDR_EVT_STAT, 32'h0);
    chk("event status", 32'h9, rd);
    apb(1'b0, ADDR_EVT_STAT, 32'h0);
    chk("status read-clear", 32'h0, rd);
    apb(1'b0, ADDR_EVT_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    // Pin reset with the long time-out
    @(posedge clk);
    fuse <= 1'b0;
    ext_n <= 1'b0;
    repeat (3) @(posedge clk);
    ext_n <= 1'b1;
    ticks = 0;
    wait_vec(VEC_RESET);
    chk_delay(LONG_N, ticks);
    cause_m = cause_m | 2;
    apb(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause", cause_m, rd);
    // Software clears the flags, then reads them back
    apb(1'b1, ADDR_CAUSE, 32'h0);
    cause_m = 0;
    apb(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause", cause_m, rd);
    apb(1'b0, ADDR_EVT_STAT, 32'h0);
    chk("event status", 32'ha, rd);
    // Watchdog pulse with its event unmasked
    apb(1'b1, ADDR_EVT_MASK, 32'h4);
    @(posedge clk);
    fuse <= 1'b1;
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    ticks = 0;
    @(negedge clk);
    chk("core reset", 32'h1, {31'h0, core_reset});
    wait_vec(VEC_RESET);
    chk_delay(SHORT_N, ticks);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause", cause_m, rd);
    apb(1'b0, ADDR_EVT_STAT, 32'h0);
    chk("event status", 32'hc, rd);
    @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Coinciding requests: lower vector first
    apb(1'b1, ADDR_IRQ_EN, 32'h3);
    @(posedge clk);
    set_ext <= 1'b1;
    set_tmr <= 1'b1;
    @(posedge clk);
    set_ext <= 1'b0;
    set_tmr <= 1'b0;
    gie <= 1'b1;
    wait_vec(VEC_EXT);
    wait_vec(VEC_TMR);
    // Random enable and global enable combinations
    for (int i = 0; i < 8; i++) begin
      en = 2'($urandom % 4);
      g = 1'($urandom % 2);
      @(posedge clk);
      gie <= 1'b0;
      apb(1'b1, ADDR_IRQ_EN, {30'h0, en});
      @(posedge clk);
      gie <= g;
      set_ext <= 1'b1;
      @(posedge clk);
      set_ext <= 1'b0;
      n0 = taken_n;
      repeat (12) @(negedge clk);
      chk("ext taken", {31'h0, en[0] & g}, taken_n - n0);
      if (taken_n == n0) begin
        @(posedge clk);
        gie <= 1'b0;
        apb(1'b1, ADDR_IRQ_EN, 32'h1);
        @(posedge clk);
        gie <= 1'b1;
        wait_vec(VEC_EXT);
      end
    end
    chk("vector under reset", 32'h0, bad_vec);
    report_and_stop();
  end
endmodule
`default_nettype wire
